// [design/regset_pkg.sv]
// Shared constants and types for the register set and flag word
package regset_pkg;
  localparam int DATA_W = 16;
  // Flag word bit positions
  localparam int CARRY_POS = 0;
  localparam int PARITY_POS = 2;
  localparam int AUX_POS = 4;
  localparam int ZERO_POS = 6;
  localparam int SIGN_POS = 7;
  localparam int STEP_POS = 8;
  localparam int INT_EN_POS = 9;
  localparam int DIR_POS = 10;
  localparam int OVF_POS = 11;
  // Bits that hold a defined function
  localparam logic [15:0] FLAG_DEFINED_MASK = 16'h0FD5;
  // Values after reset
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Register file indices (read/write port addresses)
  localparam logic [4:0] IDX_ACC = 5'h00;
  localparam logic [4:0] IDX_COUNT = 5'h01;
  localparam logic [4:0] IDX_DATA = 5'h02;
  localparam logic [4:0] IDX_BASE = 5'h03;
  localparam logic [4:0] IDX_SP = 5'h04;
  localparam logic [4:0] IDX_BP = 5'h05;
  localparam logic [4:0] IDX_SI = 5'h06;
  localparam logic [4:0] IDX_DI = 5'h07;
  localparam logic [4:0] IDX_SEG0 = 5'h08;
  localparam logic [4:0] IDX_SEG3 = 5'h0B;
  localparam logic [4:0] IDX_IP = 5'h0C;
  localparam logic [4:0] IDX_FLAGS = 5'h0D;
  localparam logic [4:0] IDX_MSW = 5'h0E;
  localparam logic [4:0] IDX_MODE = 5'h0F;
  localparam logic [4:0] IDX_BYTE_LO = 5'h10;
  localparam logic [4:0] IDX_BYTE_HI = 5'h14;
  localparam logic [4:0] IDX_STATUS = 5'h18;
  localparam logic [4:0] IDX_EA = 5'h19;
  // Address space limits
  localparam logic [23:0] REAL_ADDR_LIMIT = 24'h0FFFFF;
  localparam logic [23:0] PHYS_ADDR_LIMIT = 24'hFFFFFF;

  // ALU operation classes reported to the flag logic
  typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_LOGIC, OP_INC, OP_DEC} alu_op_t;

  // Result report from the execution datapath
  typedef struct packed {
    logic valid;
    logic byte_op;
    alu_op_t op;
    logic [15:0] a;
    logic [15:0] b;
    logic carry_in;
  } alu_report_t;

  // Operand source/destination kinds
  typedef enum logic [1:0] {LOC_REG, LOC_IMM, LOC_MEM} operand_loc_t;

  // Addressing request: base/index choice and displacement
  typedef struct packed {
    logic [1:0] base_sel;
    logic [1:0] index_sel;
    logic use_base;
    logic use_index;
    logic [15:0] disp;
  } ea_req_t;
endpackage : regset_pkg

// [design/flag_logic.sv]
// Computes the arithmetic result and its status flags
`timescale 1ns/100ps
module flag_logic (
  input regset_pkg::alu_report_t rep,
  output logic [15:0] result,
  output logic [15:0] flags_out,
  output logic [15:0] flags_mask
);
  import regset_pkg::*;
  logic [16:0] wide;
  logic [4:0] nib;
  logic msb_a, msb_b, msb_r;
  logic [15:0] res_m;

  // Result and flag derivation for one operation
  always_comb begin
    wide = 17'h00000;
    nib = 5'h00;
    flags_out = 16'h0000;
    flags_mask = 16'h0000;
    case (rep.op)
      OP_ADD: begin
        wide = {1'b0, rep.a} + {1'b0, rep.b} + {16'h0000, rep.carry_in};
        nib = {1'b0, rep.a[3:0]} + {1'b0, rep.b[3:0]} + {4'h0, rep.carry_in};
      end
      OP_SUB: begin
        wide = {1'b0, rep.a} - {1'b0, rep.b} - {16'h0000, rep.carry_in};
        nib = {1'b0, rep.a[3:0]} - {1'b0, rep.b[3:0]} - {4'h0, rep.carry_in};
      end
      OP_INC: begin
        wide = {1'b0, rep.a} + 17'h00001;
        nib = {1'b0, rep.a[3:0]} + 5'h01;
      end
      OP_DEC: begin
        wide = {1'b0, rep.a} - 17'h00001;
        nib = {1'b0, rep.a[3:0]} - 5'h01;
      end
      OP_LOGIC: wide = {1'b0, rep.a ^ rep.b};
      default: wide = 17'h00000;
    endcase
    res_m = rep.byte_op ? {8'h00, wide[7:0]} : wide[15:0];
    msb_a = rep.byte_op ? rep.a[7] : rep.a[15];
    msb_b = (rep.op == OP_INC || rep.op == OP_DEC) ? 1'b0 :
            (rep.byte_op ? rep.b[7] : rep.b[15]);
    msb_r = rep.byte_op ? wide[7] : wide[15];
    // Carry out of the top result bit
    if (rep.byte_op) begin
      flags_out[CARRY_POS] = (rep.op == OP_SUB) ? (rep.a[7:0] < rep.b[7:0] ||
        (rep.a[7:0] == rep.b[7:0] && rep.carry_in)) : (wide[8] ^ rep.a[8] ^ rep.b[8]);
    end else begin
      flags_out[CARRY_POS] = wide[16];
    end
    flags_out[PARITY_POS] = ~^wide[7:0];
    flags_out[AUX_POS] = nib[4];
    flags_out[ZERO_POS] = (res_m == 16'h0000);
    flags_out[SIGN_POS] = msb_r;
    // Signed overflow: add/inc when operands agree in sign and result differs; sub/dec when operands differ and result differs from a
    if (rep.op == OP_SUB || rep.op == OP_DEC) begin
      flags_out[OVF_POS] = (msb_a != msb_b) && (msb_r != msb_a);
    end else if (rep.op == OP_LOGIC) begin
      flags_out[OVF_POS] = 1'b0;
    end else begin
      flags_out[OVF_POS] = (msb_a == msb_b) && (msb_r != msb_a);
    end
    // Logic ops leave carry clear too; inc/dec keep the old carry
    if (rep.op == OP_LOGIC) begin
      flags_out[CARRY_POS] = 1'b0;
      flags_out[AUX_POS] = 1'b0;
    end
    flags_mask = 16'((1 << CARRY_POS) | (1 << PARITY_POS) | (1 << AUX_POS) |
                 (1 << ZERO_POS) | (1 << SIGN_POS) | (1 << OVF_POS));
    if (rep.op == OP_INC || rep.op == OP_DEC) begin
      flags_mask[CARRY_POS] = 1'b0;
    end
    result = res_m;
  end
endmodule : flag_logic

// [design/cpu_register_set_flags.sv]
// Architectural register set with flag word and address helpers
// Behaviour
// - Flag word is one 16-bit register
// - Carry flag tracks top-bit carry or borrow
// - Parity flag set on even low-byte ones
// - Aux carry tracks low-nibble carry or borrow
// - Zero flag set on zero result
// - Sign flag copies result top bit
// - Overflow flag set on signed overflow
// - Single-step trap after next instruction, clears flag
// - Interrupt enable gates maskable interrupts
// - Eight general words, four byte-splittable
// - Four 16-bit segment registers
// - Three status/control words including instruction pointer
// - Four registers serve as base or index
// - Operand routes; memory-to-memory only via strings
// - Real one megabyte, protected sixteen megabyte mapping
`timescale 1ns/100ps
module cpu_register_set_flags (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input regset_pkg::alu_report_t alu_rep,
  input wire logic alu_write,
  input wire logic [4:0] alu_dest,
  input wire logic insn_done,
  input wire logic [15:0] next_ip,
  input wire logic int_req,
  input wire logic [15:0] int_vector_addr,
  output logic int_taken,
  output logic step_trap,
  input regset_pkg::operand_loc_t src_loc,
  input regset_pkg::operand_loc_t dst_loc,
  input wire logic string_op,
  output logic route_ok,
  input wire logic string_step,
  input wire logic string_byte,
  input regset_pkg::ea_req_t ea_req,
  input wire logic [1:0] seg_sel,
  output logic [15:0] ea_q,
  output logic [23:0] phys_addr_q,
  output logic addr_fault_q,
  output logic [15:0] flags_q_out
);
  import regset_pkg::*;

  logic [15:0] gen_q [0:7];
  logic [15:0] seg_q [0:3];
  logic [15:0] ip_q;
  logic [15:0] msw_q;
  logic [15:0] flags_q;
  logic mode_prot_q;
  logic [15:0] alu_result;
  logic [15:0] alu_flags;
  logic [15:0] alu_mask;
  logic [15:0] rdata_q;
  logic step_pend_q;
  logic [15:0] step_sz;
  logic [15:0] ea_d;
  logic [23:0] phys_d;

  // Flag and result computation for the reported operation
  flag_logic u_flags (
    .rep(alu_rep),
    .result(alu_result),
    .flags_out(alu_flags),
    .flags_mask(alu_mask)
  );

  // Software write to a general register; byte indices hit the four split words
  function automatic logic [15:0] merge_byte(input logic [15:0] old, input logic hi,
                                             input logic [7:0] b);
    merge_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : merge_byte

  // General registers, with byte halves for the first four
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        gen_q[i] <= REG_RESET;
      end
    end else begin
      if (wr && addr <= IDX_DI) begin
        gen_q[addr[2:0]] <= wdata;
      end else if (wr && addr >= IDX_BYTE_LO && addr < IDX_STATUS) begin
        gen_q[addr[1:0]] <= merge_byte(gen_q[addr[1:0]], addr >= IDX_BYTE_HI,
                                       wdata[7:0]);
      end
      if (alu_rep.valid && alu_write && alu_dest <= IDX_DI) begin
        gen_q[alu_dest[2:0]] <= alu_rep.byte_op ?
          merge_byte(gen_q[alu_dest[2:0]], 1'b0, alu_result[7:0]) : alu_result;
      end
      // Index auto-step for strings: source and destination index move together
      if (string_step) begin
        gen_q[IDX_SI[2:0]] <= gen_q[IDX_SI[2:0]] + step_sz;
        gen_q[IDX_DI[2:0]] <= gen_q[IDX_DI[2:0]] + step_sz;
      end
    end
  end

  // Step is one or two, negated when the direction flag is set
  always_comb begin
    step_sz = string_byte ? 16'h0001 : 16'h0002;
    if (flags_q[DIR_POS]) begin
      step_sz = 16'h0000 - step_sz;
    end
  end

  // Segment registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        seg_q[i] <= REG_RESET;
      end
    end else if (wr && addr >= IDX_SEG0 && addr <= IDX_SEG3) begin
      seg_q[addr[1:0]] <= wdata;
    end
  end

  // Instruction pointer tracks the next sequential instruction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ip_q <= IP_RESET;
    end else if (int_taken) begin
      ip_q <= int_vector_addr;
    end else if (insn_done) begin
      ip_q <= next_ip;
    end else if (wr && addr == IDX_IP) begin
      ip_q <= wdata;
    end
  end

  // Machine status word and addressing mode select
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msw_q <= REG_RESET;
      mode_prot_q <= 1'b0;
    end else begin
      if (wr && addr == IDX_MSW) begin
        msw_q <= wdata;
      end
      if (wr && addr == IDX_MODE) begin
        mode_prot_q <= wdata[0];
      end
    end
  end

  // Single-step: armed by the flag at an instruction end, fires at the next one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_pend_q <= 1'b0;
    end else if (step_trap) begin
      step_pend_q <= 1'b0;
    end else if (insn_done && flags_q[STEP_POS]) begin
      step_pend_q <= 1'b1;
    end
  end

  assign step_trap = insn_done && step_pend_q;
  // Maskable interrupt taken only at an instruction end with enable set
  assign int_taken = insn_done && int_req && flags_q[INT_EN_POS] && !step_trap;

  // Flag word: results update only defined result bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= FLAGS_RESET;
    end else if (wr && addr == IDX_FLAGS) begin
      flags_q <= wdata & FLAG_DEFINED_MASK;
    end else begin
      if (alu_rep.valid) begin
        flags_q <= (flags_q & ~alu_mask) | (alu_flags & alu_mask);
      end
      // Trap entry drops the step flag; an interrupt entry drops only the enable flag
      if (step_trap) begin
        flags_q[STEP_POS] <= 1'b0;
      end
      if (int_taken) begin
        flags_q[INT_EN_POS] <= 1'b0;
      end
    end
  end

  assign flags_q_out = flags_q;

  // Only memory-to-memory needs the string path; immediates never a destination
  assign route_ok = (dst_loc != LOC_IMM) &&
                    !(src_loc == LOC_MEM && dst_loc == LOC_MEM && !string_op);

  // Offset from base (base word or frame pointer) plus index (source/dest index)
  always_comb begin
    ea_d = ea_req.disp;
    if (ea_req.use_base) begin
      ea_d = ea_d + (ea_req.base_sel[0] ? gen_q[IDX_BP[2:0]] : gen_q[IDX_BASE[2:0]]);
    end
    if (ea_req.use_index) begin
      ea_d = ea_d + (ea_req.index_sel[0] ? gen_q[IDX_DI[2:0]] : gen_q[IDX_SI[2:0]]);
    end
    phys_d = {seg_q[seg_sel], 8'h00} + {8'h00, ea_d};
    if (!mode_prot_q) begin
      phys_d = {4'h0, seg_q[seg_sel], 4'h0} + {8'h00, ea_d};
    end
  end

  // Registered address outputs; wrap past the real-mode limit is a fault flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ea_q <= 16'h0000;
      phys_addr_q <= 24'h000000;
      addr_fault_q <= 1'b0;
    end else begin
      ea_q <= ea_d;
      phys_addr_q <= mode_prot_q ? (phys_d & PHYS_ADDR_LIMIT) : (phys_d & {4'h0, 20'hFFFFF});
      addr_fault_q <= !mode_prot_q && (phys_d > REAL_ADDR_LIMIT);
    end
  end

  // Read port: data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      if (addr <= IDX_DI) begin
        rdata_q <= gen_q[addr[2:0]];
      end else if (addr >= IDX_SEG0 && addr <= IDX_SEG3) begin
        rdata_q <= seg_q[addr[1:0]];
      end else if (addr == IDX_IP) begin
        rdata_q <= ip_q;
      end else if (addr == IDX_FLAGS) begin
        rdata_q <= flags_q;
      end else if (addr == IDX_MSW) begin
        rdata_q <= msw_q;
      end else if (addr == IDX_MODE) begin
        rdata_q <= {15'h0000, mode_prot_q};
      end else if (addr >= IDX_BYTE_LO && addr < IDX_STATUS) begin
        rdata_q <= {8'h00, (addr >= IDX_BYTE_HI) ? gen_q[addr[1:0]][15:8]
                                                 : gen_q[addr[1:0]][7:0]};
      end else if (addr == IDX_STATUS) begin
        rdata_q <= {14'h0000, step_pend_q, addr_fault_q};
      end else if (addr == IDX_EA) begin
        rdata_q <= ea_q;
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  assign rdata = rdata_q;

  // Reserved flag bits never become set
  a_reserved_bits: assert property (@(posedge clk) disable iff (!rst_b)
    (flags_q & ~FLAG_DEFINED_MASK) == 16'h0000) else $error("reserved flag bit set");
  a_zero_flag: assert property (@(posedge clk) disable iff (!rst_b)
    alu_rep.valid && !(wr && addr == IDX_FLAGS) |=> flags_q[ZERO_POS] ==
    ($past(alu_result) == 16'h0000)) else $error("zero flag mismatch");
  a_parity_flag: assert property (@(posedge clk) disable iff (!rst_b)
    alu_rep.valid && !(wr && addr == IDX_FLAGS) |=> flags_q[PARITY_POS] ==
    ~^$past(alu_result[7:0])) else $error("parity flag mismatch");
  a_sign_flag: assert property (@(posedge clk) disable iff (!rst_b)
    alu_rep.valid && !alu_rep.byte_op && !(wr && addr == IDX_FLAGS) |=>
    flags_q[SIGN_POS] == $past(alu_result[15])) else $error("sign flag mismatch");
  a_carry_word: assert property (@(posedge clk) disable iff (!rst_b)
    alu_rep.valid && !alu_rep.byte_op && alu_rep.op == OP_ADD && !(wr && addr == IDX_FLAGS)
    |=> flags_q[CARRY_POS] == ($past(alu_result) < $past(alu_rep.a) ||
    ($past(alu_rep.carry_in) && $past(alu_result) == $past(alu_rep.a))))
    else $error("carry flag mismatch");
  a_step_trap: assert property (@(posedge clk) disable iff (!rst_b)
    step_trap |=> !flags_q[STEP_POS]) else $error("step flag not cleared");
  a_int_gate: assert property (@(posedge clk) disable iff (!rst_b)
    int_taken |-> flags_q[INT_EN_POS] && insn_done) else $error("interrupt not gated");
  a_read_latency: assert property (@(posedge clk) disable iff (!rst_b)
    rd && addr == IDX_IP && !insn_done && !int_taken ##0 !wr |=> rdata == $past(ip_q))
    else $error("read data wrong");
  a_route_mem: assert property (@(posedge clk) disable iff (!rst_b)
    src_loc == LOC_MEM && dst_loc == LOC_MEM && !string_op |-> !route_ok)
    else $error("memory to memory allowed");
  c_step_fire: cover property (@(posedge clk) disable iff (!rst_b) step_trap);
  c_int_taken: cover property (@(posedge clk) disable iff (!rst_b) int_taken);
  c_string_down: cover property (@(posedge clk) disable iff (!rst_b)
    string_step && flags_q[DIR_POS]);

  // Remaining checks share one clock and reset
  default clocking def_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // A software flag write lands masked and beats any result
  a_flag_write: assert property (
    wr && addr == IDX_FLAGS |=>
    flags_q == ($past(wdata) & FLAG_DEFINED_MASK))
    else $error("flag write wrong");
  // Logic ops clear carry class flags; inc and dec leave carry alone
  a_logic_clear: assert property (
    alu_rep.valid && alu_rep.op == OP_LOGIC && !(wr && addr == IDX_FLAGS) |=>
    !flags_q[CARRY_POS] && !flags_q[AUX_POS] && !flags_q[OVF_POS])
    else $error("logic flags not cleared");
  a_carry_keep: assert property (
    alu_rep.valid && (alu_rep.op == OP_INC || alu_rep.op == OP_DEC) &&
    !(wr && addr == IDX_FLAGS) |=> $stable(flags_q[CARRY_POS]))
    else $error("carry not kept");

  // Nibble carry and signed overflow on additions
  a_aux_add: assert property (
    alu_rep.valid && alu_rep.op == OP_ADD && !(wr && addr == IDX_FLAGS) |=>
    flags_q[AUX_POS] == ($past(alu_rep.a[4]) ^ $past(alu_rep.b[4]) ^
    $past(alu_result[4])))
    else $error("aux carry mismatch");
  a_ovf_add: assert property (
    alu_rep.valid && alu_rep.op == OP_ADD && !alu_rep.byte_op &&
    !(wr && addr == IDX_FLAGS) |=> flags_q[OVF_POS] ==
    ($past(alu_rep.a[15]) == $past(alu_rep.b[15]) &&
    $past(alu_result[15]) != $past(alu_rep.a[15])))
    else $error("overflow mismatch");

  // String index steps, only when nothing else writes the registers
  a_string_up: assert property (
    string_step && !flags_q[DIR_POS] && string_byte && !wr && !alu_rep.valid |=>
    gen_q[6] == $past(gen_q[6]) + 16'h0001)
    else $error("index did not step up");
  a_string_down: assert property (
    string_step && flags_q[DIR_POS] && !string_byte && !wr && !alu_rep.valid |=>
    gen_q[7] == $past(gen_q[7]) - 16'h0002)
    else $error("index did not step down");

  // Software writes to word registers
  a_gen_write: assert property (
    wr && addr <= IDX_DI && !alu_rep.valid && !string_step |=>
    gen_q[$past(addr[2:0])] == $past(wdata))
    else $error("general write lost");
  a_seg_write: assert property (
    wr && addr >= IDX_SEG0 && addr <= IDX_SEG3 |=>
    seg_q[$past(addr[1:0])] == $past(wdata))
    else $error("segment write lost");

  // Pointer follows completions; an interrupt entry loads the vector
  a_ip_next: assert property (
    insn_done && !int_taken |=> ip_q == $past(next_ip))
    else $error("pointer not advanced");
  a_int_vector: assert property (
    int_taken && !(wr && addr == IDX_FLAGS) |=>
    ip_q == $past(int_vector_addr) && !flags_q[INT_EN_POS])
    else $error("interrupt entry wrong");

  c_byte_write: cover property (
    wr && addr >= IDX_BYTE_LO && addr < IDX_STATUS);
  c_alu_byte: cover property (
    alu_rep.valid && alu_rep.byte_op && alu_write);
endmodule : cpu_register_set_flags

// [bench/exec_model.sv]
// Execution datapath stand-in that reports results and completions
`timescale 1ns/100ps
module exec_model (
  input wire logic clk,
  output regset_pkg::alu_report_t rep,
  output logic we,
  output logic [4:0] dst,
  output logic done,
  output logic [15:0] nip
);
  import regset_pkg::*;
  // Quiet values at time zero
  initial begin
    rep = '0;
    we = 1'b0;
    dst = 5'h00;
    done = 1'b0;
    nip = 16'h0000;
  end
  // One-cycle report; operands scrambled after so stale data never match
  task automatic alu(input alu_op_t op, input logic [15:0] a, b, input logic byt, w,
                     input logic [4:0] d);
    @(posedge clk);
    rep <= '{1'b1, byt, op, a, b, 1'b0};
    we <= w;
    dst <= d;
    @(posedge clk);
    rep <= '{1'b0, ~byt, op, ~a, ~b, 1'b1};
    we <= 1'b0;
    dst <= ~d;
  endtask : alu
  // One-cycle completion strobe with the following address
  task automatic fin(input logic [15:0] ip);
    @(posedge clk);
    done <= 1'b1;
    nip <= ip;
    @(posedge clk);
    done <= 1'b0;
    nip <= ~ip;
  endtask : fin
endmodule : exec_model

// [bench/cpu_register_set_flags_tb_top.sv]
// Self-checking bench for the register set and flag word
`timescale 1ns/100ps
module cpu_register_set_flags_tb_top;
  import regset_pkg::*;
  logic clk, rst_b, wr, rd, int_req, string_op, string_step, string_byte, we, done;
  logic int_taken, step_trap, route_ok, addr_fault_q, trap_seen, take_seen;
  logic [4:0] addr, dst;
  logic [15:0] wdata, rdata, ivec, ea_q, flags_q_out, nip, v, fl;
  logic [23:0] phys_addr_q;
  logic [1:0] seg_sel;
  operand_loc_t src_loc, dst_loc;
  ea_req_t ea_req;
  alu_report_t rep;
  int num_errors = 0;
  int checks_done = 0;
  logic [15:0] sh [0:7];

  exec_model m (.clk(clk), .rep(rep), .we(we), .dst(dst), .done(done), .nip(nip));
  cpu_register_set_flags uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .alu_rep(rep), .alu_write(we), .alu_dest(dst), .insn_done(done),
    .next_ip(nip), .int_req(int_req), .int_vector_addr(ivec), .int_taken(int_taken),
    .step_trap(step_trap), .src_loc(src_loc), .dst_loc(dst_loc), .string_op(string_op),
    .route_ok(route_ok), .string_step(string_step), .string_byte(string_byte),
    .ea_req(ea_req), .seg_sel(seg_sel), .ea_q(ea_q), .phys_addr_q(phys_addr_q),
    .addr_fault_q(addr_fault_q), .flags_q_out(flags_q_out));

  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Trap and interrupt pulses only live in the completion cycle
  always @(posedge clk) begin
    if (done) begin
      trap_seen <= step_trap;
      take_seen <= int_taken;
    end
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    results();
  end

  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic cmp(input string n, input logic [23:0] e, s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rreg
  // Reference flags and result from plain integer arithmetic
  function automatic logic [31:0] ref_alu(alu_op_t op, logic [15:0] a, b, logic byt);
    int w, r, x;
    logic [15:0] f;
    w = byt ? 8 : 16;
    a = byt ? {8'h00, a[7:0]} : a;
    b = byt ? {8'h00, b[7:0]} : b;
    r = (op == OP_SUB || op == OP_DEC) ? a - b : a + b;
    x = (op == OP_SUB || op == OP_DEC) ? (a ^ b) & (a ^ r) : ~(a ^ b) & (a ^ r);
    f = 16'h0000;
    f[CARRY_POS] = r[w];
    f[AUX_POS] = a[4] ^ b[4] ^ r[4];
    f[PARITY_POS] = ~^r[7:0];
    f[ZERO_POS] = (r & ((1 << w) - 1)) == 0;
    f[SIGN_POS] = r[w-1];
    f[OVF_POS] = x[w-1];
    return {f, r[15:0]};
  endfunction : ref_alu

  initial begin
    logic [31:0] e;
    logic [15:0] a, b, ef;
    alu_op_t op;
    int st;
    {wr, rd, int_req, string_op, string_step, string_byte} = '0;
    addr = 5'h00;
    wdata = 16'h0000;
    ivec = 16'h0A0C;
    src_loc = LOC_REG;
    dst_loc = LOC_REG;
    ea_req = '0;
    seg_sel = 2'h0;
    rst_b = 1'b0;
    void'($urandom(49));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    // Reset state, unmapped place and reserved flag bits
    wreg(5'h1F, 16'hFFFF);
    rreg(5'h1F, v);
    cmp("unmapped", 16'h0000, v);
    rreg(IDX_IP, v);
    cmp("ip reset", IP_RESET, v);
    wreg(IDX_FLAGS, 16'hFFFF);
    rreg(IDX_FLAGS, v);
    cmp("flag mask", FLAG_DEFINED_MASK, v);
    $display("test reset done");
    // General, byte and segment registers
    for (int i = 0; i < 12; i++) begin
      if (i < 8) sh[i] = $urandom;
      e[15:0] = (i < 8) ? sh[i] : $urandom;
      wreg(i[4:0], e[15:0]);
      rreg(i[4:0], v);
      cmp("reg", e[15:0], v);
    end
    rreg(IDX_BYTE_HI + 5'h01, v);
    cmp("byte hi", {8'h00, sh[1][15:8]}, v);
    wreg(IDX_BYTE_LO, 16'h00A5);
    sh[0][7:0] = 8'hA5;
    rreg(IDX_ACC, v);
    cmp("byte lo", sh[0], v);
    $display("test registers done");
    // Arithmetic results and flags, word and byte, every class
    wreg(IDX_FLAGS, 16'h0000);
    fl = 16'h0000;
    for (int i = 0; i < 40; i++) begin
      op = alu_op_t'(i % 5);
      a = $urandom;
      b = (op == OP_INC || op == OP_DEC) ? 16'h0001 : (i % 8 == 3) ? a : $urandom;
      m.alu(op, a, b, (i / 5) % 2, op != OP_LOGIC, i[4:0] % 5'h08);
      @(negedge clk);
      e = ref_alu(op, a, b, (i / 5) % 2);
      if (op == OP_LOGIC) begin
        cmp("logic flags", 16'h0000, flags_q_out & 16'h0811);
        fl = fl & 16'hF7EE;
      end else begin
        ef = (fl & ~16'h08D5) | e[31:16];
        if (op == OP_INC || op == OP_DEC) ef[CARRY_POS] = fl[CARRY_POS];
        cmp("flags", ef, flags_q_out);
        fl = ef;
        st = i % 8;
        sh[st] = ((i / 5) % 2) ? {sh[st][15:8], e[7:0]} : e[15:0];
      end
      rreg(i[4:0] % 5'h08, v);
      cmp("dest", sh[i % 8], v);
    end
    $display("test alu done");
    // Single-step arms on one completion and traps on the next
    wreg(IDX_FLAGS, 16'h0100);
    m.fin(16'h0040);
    @(negedge clk);
    cmp("no trap yet", 1'b0, trap_seen);
    m.fin(16'h0042);
    @(negedge clk);
    cmp("trap", 1'b1, trap_seen);
    cmp("step cleared", 1'b0, flags_q_out[STEP_POS]);
    $display("test step done");
    // Masked then enabled interrupt
    @(posedge clk);
    int_req <= 1'b1;
    wreg(IDX_FLAGS, 16'h0000);
    m.fin(16'h0050);
    rreg(IDX_IP, v);
    cmp("masked", 1'b0, take_seen);
    cmp("ip next", 16'h0050, v);
    wreg(IDX_FLAGS, 16'h0200);
    m.fin(16'h0060);
    rreg(IDX_IP, v);
    cmp("taken", 1'b1, take_seen);
    cmp("ip vector", ivec, v);
    cmp("if cleared", 1'b0, flags_q_out[INT_EN_POS]);
    @(posedge clk);
    int_req <= 1'b0;
    $display("test interrupt done");
    // String index stepping, both sizes and directions
    for (int k = 0; k < 4; k++) begin
      wreg(IDX_FLAGS, k[1] ? 16'h0400 : 16'h0000);
      wreg(IDX_SI, 16'h1000);
      wreg(IDX_DI, 16'h2000);
      @(posedge clk);
      string_byte <= k[0];
      string_step <= 1'b1;
      @(posedge clk);
      string_step <= 1'b0;
      st = k[0] ? 1 : 2;
      if (k[1]) st = -st;
      rreg(IDX_SI, v);
      cmp("src index", 16'h1000 + st, v);
      rreg(IDX_DI, v);
      cmp("dst index", 16'h2000 + st, v);
    end
    $display("test string done");
    // Operand routes over every source, destination and string mode
    for (int s = 0; s < 6; s++) begin
      for (int d = 0; d < 3; d++) begin
        @(posedge clk);
        src_loc <= operand_loc_t'(s % 3);
        dst_loc <= operand_loc_t'(d);
        string_op <= s / 3;
        @(negedge clk);
        cmp("route", d != 1 && (s % 3 != 2 || d != 2 || s / 3 == 1), route_ok);
      end
    end
    $display("test route done");
    // Real-mode address at the top of the megabyte and just past it
    wreg(IDX_SEG0, 16'hFFFF);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      ea_req <= '{2'h0, 2'h0, 1'b0, 1'b0, 16'h000F + k};
      @(posedge clk);
      @(negedge clk);
      cmp("offset", 16'h000F + k, ea_q);
      cmp("phys", k ? 24'h000000 : 24'h0FFFFF, phys_addr_q);
      cmp("fault", k, addr_fault_q);
    end
    $display("test address done");
    results();
  end
endmodule : cpu_register_set_flags_tb_top
